/* common/qos_map_pkg.sv */
// Constants and types shared by the QoS priority map tables.
package qos_map_pkg;

    // ========================================================================
    // Register indices; byte address is four times the index.
    localparam logic [7:0] IDX_GLOBAL_CTRL = 8'h00;
    localparam logic [7:0] IDX_TAG_EN      = 8'h04;
    localparam logic [7:0] IDX_CP_EN       = 8'h08;
    localparam logic [7:0] IDX_TAG_MAP     = 8'h10;
    localparam logic [7:0] IDX_STATUS      = 8'h20;
    localparam logic [7:0] IDX_CP_MAP0     = 8'h30;
    localparam logic [7:0] IDX_CP_MAP1     = 8'h36;
    localparam logic [7:0] IDX_CP_MAP2     = 8'h3c;

    // ========================================================================
    // Field positions and widths.
    localparam int NUM_PORTS       = 17;
    localparam int TAG_MAP_W       = 24;
    localparam int CP_MAP_W        = 48;
    localparam int CP_HI_W         = 16;
    localparam int FIELD_W         = 3;
    localparam int SEL_LSB         = 2;
    localparam int PORT_QOS_BIT    = 6;
    localparam int STATUS_VLD_BIT  = 3;
    localparam int ADDR_IDX_LSB    = 2;

    // ========================================================================
    // Reset values.
    localparam logic [TAG_MAP_W-1:0] TAG_MAP_RST = 24'h000000;
    localparam logic [CP_MAP_W-1:0]  CP_MAP_RST  = 48'h000000000000;
    localparam logic [NUM_PORTS-1:0] PORT_EN_RST = 17'h00000;
    localparam logic [1:0]           SEL_RST     = 2'h0;

    // Cycles after reset release at which the synchronised strap is taken.
    localparam logic [1:0] STRAP_TAKE_CNT = 2'h2;

    // ========================================================================
    // Types.
    typedef enum logic [1:0] {
        SRC_L2         = 2'b00,
        SRC_IP_ONLY    = 2'b01,
        SRC_IP_ELSE_L2 = 2'b10,
        SRC_MAX        = 2'b11
    } src_sel_e;

    typedef enum logic [1:0] {
        CP_BANK0 = 2'b00,
        CP_BANK1 = 2'b01,
        CP_BANK2 = 2'b10,
        CP_EXT   = 2'b11
    } cp_bank_e;

endpackage

/* hw/qos_map_lookup.sv */
// Table lookup: tag value and code point to 3-bit priority IDs.
`timescale 1ns/1ps
module qos_map_lookup (
    input  wire logic [23:0] tag_map,
    input  wire logic [47:0] cp_map0,
    input  wire logic [47:0] cp_map1,
    input  wire logic [47:0] cp_map2,
    input  wire logic [2:0]  tag,
    input  wire logic [5:0]  codepoint,
    input  wire logic [2:0]  ext_prio,
    output logic      [2:0]  tag_prio,
    output logic      [2:0]  cp_prio
);

    // ========================================================================
    // Field selection.
    function automatic logic [2:0] field3(input logic [47:0] tbl, input logic [3:0] idx);
        field3 = tbl[{2'h0, idx} * 6'd3 +: 3];
    endfunction

    always_comb begin
        tag_prio = field3({24'h000000, tag_map}, {1'b0, tag});
        unique case (qos_map_pkg::cp_bank_e'(codepoint[5:4]))
            qos_map_pkg::CP_BANK0: cp_prio = field3(cp_map0, codepoint[3:0]);
            qos_map_pkg::CP_BANK1: cp_prio = field3(cp_map1, codepoint[3:0]);
            qos_map_pkg::CP_BANK2: cp_prio = field3(cp_map2, codepoint[3:0]);
            qos_map_pkg::CP_EXT:   cp_prio = ext_prio;
        endcase
    end

endmodule

/* hw/qos_priority_map_tables.sv */
// QoS priority map tables with AHB-Lite register slave and lookup pipeline.
`timescale 1ns/1ps
module qos_priority_map_tables (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    input  wire logic        port_qos_strap,
    input  wire logic        lookup_valid,
    input  wire logic [4:0]  lookup_port,
    input  wire logic        lookup_tagged,
    input  wire logic        lookup_is_ip,
    input  wire logic [2:0]  lookup_tag,
    input  wire logic [5:0]  lookup_codepoint,
    input  wire logic [2:0]  lookup_mac_prio,
    input  wire logic [2:0]  lookup_port_prio,
    output logic      [5:0]  cp_ext_code,
    input  wire logic [2:0]  cp_ext_prio,
    output logic             prio_valid,
    output logic      [2:0]  prio_id
);

    // ========================================================================
    // State.
    typedef struct packed {
        logic [23:0] tag_map;
        logic [47:0] cp_map0;
        logic [47:0] cp_map1;
        logic [47:0] cp_map2;
        logic [1:0]  src_sel;
        logic        port_qos_en;
        logic [16:0] tag_en;
        logic [16:0] cp_en;
        logic        strap_meta;
        logic        strap_sync;
        logic [1:0]  strap_cnt;
        logic        wr_pend;
        logic [7:0]  wr_idx;
        logic        rd_wait;
        logic [7:0]  rd_idx;
        logic        hreadyout;
        logic [31:0] hrdata;
        logic        hresp;
        logic        s1_valid;
        logic [4:0]  s1_port;
        logic        s1_tagged;
        logic        s1_is_ip;
        logic [2:0]  s1_tag;
        logic [5:0]  s1_cp;
        logic [2:0]  s1_mac_prio;
        logic [2:0]  s1_port_prio;
        logic        prio_valid;
        logic [2:0]  prio_id;
        logic        last_valid;
        logic [2:0]  last_prio;
    } state_s;

    localparam state_s STATE_RST = '{
        tag_map:      qos_map_pkg::TAG_MAP_RST,
        cp_map0:      qos_map_pkg::CP_MAP_RST,
        cp_map1:      qos_map_pkg::CP_MAP_RST,
        cp_map2:      qos_map_pkg::CP_MAP_RST,
        src_sel:      qos_map_pkg::SEL_RST,
        port_qos_en:  1'b0,
        tag_en:       qos_map_pkg::PORT_EN_RST,
        cp_en:        qos_map_pkg::PORT_EN_RST,
        strap_meta:   1'b0,
        strap_sync:   1'b0,
        strap_cnt:    2'h0,
        wr_pend:      1'b0,
        wr_idx:       8'h00,
        rd_wait:      1'b0,
        rd_idx:       8'h00,
        hreadyout:    1'b1,
        hrdata:       32'h00000000,
        hresp:        1'b0,
        s1_valid:     1'b0,
        s1_port:      5'h00,
        s1_tagged:    1'b0,
        s1_is_ip:     1'b0,
        s1_tag:       3'h0,
        s1_cp:        6'h00,
        s1_mac_prio:  3'h0,
        s1_port_prio: 3'h0,
        prio_valid:   1'b0,
        prio_id:      3'h0,
        last_valid:   1'b0,
        last_prio:    3'h0
    };

    state_s state_reg;
    state_s state_next;

    logic [2:0] tag_prio;
    logic [2:0] cp_prio;

    // ========================================================================
    // Helpers.
    function automatic logic idx_is(input logic [7:0] idx, input logic [7:0] target);
        idx_is = (idx == target);
    endfunction

    function automatic logic [2:0] max3(input logic [2:0] a, input logic [2:0] b);
        max3 = (a > b) ? a : b;
    endfunction

    function automatic logic [31:0] read_word(input state_s s, input logic [7:0] idx);
        read_word = 32'h00000000;
        if (idx_is(idx, qos_map_pkg::IDX_GLOBAL_CTRL)) begin
            read_word[qos_map_pkg::SEL_LSB +: 2]  = s.src_sel;
            read_word[qos_map_pkg::PORT_QOS_BIT]  = s.port_qos_en;
        end
        if (idx_is(idx, qos_map_pkg::IDX_TAG_EN)) begin
            read_word[16:0] = s.tag_en;
        end
        if (idx_is(idx, qos_map_pkg::IDX_CP_EN)) begin
            read_word[16:0] = s.cp_en;
        end
        if (idx_is(idx, qos_map_pkg::IDX_TAG_MAP)) begin
            read_word[23:0] = s.tag_map;
        end
        if (idx_is(idx, qos_map_pkg::IDX_STATUS)) begin
            read_word[2:0]                          = s.last_prio;
            read_word[qos_map_pkg::STATUS_VLD_BIT]  = s.last_valid;
        end
        if (idx_is(idx, qos_map_pkg::IDX_CP_MAP0)) begin
            read_word = s.cp_map0[31:0];
        end
        if (idx_is(idx, qos_map_pkg::IDX_CP_MAP0 + 8'h01)) begin
            read_word[15:0] = s.cp_map0[47:32];
        end
        if (idx_is(idx, qos_map_pkg::IDX_CP_MAP1)) begin
            read_word = s.cp_map1[31:0];
        end
        if (idx_is(idx, qos_map_pkg::IDX_CP_MAP1 + 8'h01)) begin
            read_word[15:0] = s.cp_map1[47:32];
        end
        if (idx_is(idx, qos_map_pkg::IDX_CP_MAP2)) begin
            read_word = s.cp_map2[31:0];
        end
        if (idx_is(idx, qos_map_pkg::IDX_CP_MAP2 + 8'h01)) begin
            read_word[15:0] = s.cp_map2[47:32];
        end
    endfunction

    // ========================================================================
    // Table lookup for the request held in the first stage.
    qos_map_lookup u_lookup (
        .tag_map   (state_reg.tag_map),
        .cp_map0   (state_reg.cp_map0),
        .cp_map1   (state_reg.cp_map1),
        .cp_map2   (state_reg.cp_map2),
        .tag       (state_reg.s1_tag),
        .codepoint (state_reg.s1_cp),
        .ext_prio  (cp_ext_prio),
        .tag_prio  (tag_prio),
        .cp_prio   (cp_prio)
    );

    // ========================================================================
    // Next state.
    always_comb begin
        logic        accept;
        logic        tag_ok;
        logic        cp_ok;
        logic [2:0]  tag_term;
        logic [2:0]  cp_term;
        logic [2:0]  l2_prio;
        logic [2:0]  result;
        accept   = 1'b0;
        tag_ok   = 1'b0;
        cp_ok    = 1'b0;
        tag_term = 3'h0;
        cp_term  = 3'h0;
        l2_prio  = 3'h0;
        result   = 3'h0;
        state_next = state_reg;

        // Strap is synchronised, then taken once shortly after reset release.
        state_next.strap_meta = port_qos_strap;
        state_next.strap_sync = state_reg.strap_meta;
        if (state_reg.strap_cnt != 2'h3) begin
            state_next.strap_cnt = state_reg.strap_cnt + 2'h1;
        end
        if (state_reg.strap_cnt == qos_map_pkg::STRAP_TAKE_CNT) begin
            state_next.port_qos_en = state_reg.strap_sync;
        end

        // Write data phase; unmapped indices are ignored.
        state_next.wr_pend = 1'b0;
        if (state_reg.wr_pend) begin
            if (idx_is(state_reg.wr_idx, qos_map_pkg::IDX_GLOBAL_CTRL)) begin
                state_next.src_sel     = hwdata[qos_map_pkg::SEL_LSB +: 2];
                state_next.port_qos_en = hwdata[qos_map_pkg::PORT_QOS_BIT];
            end
            if (idx_is(state_reg.wr_idx, qos_map_pkg::IDX_TAG_EN)) begin
                state_next.tag_en = hwdata[16:0];
            end
            if (idx_is(state_reg.wr_idx, qos_map_pkg::IDX_CP_EN)) begin
                state_next.cp_en = hwdata[16:0];
            end
            if (idx_is(state_reg.wr_idx, qos_map_pkg::IDX_TAG_MAP)) begin
                state_next.tag_map = hwdata[23:0];
            end
            if (idx_is(state_reg.wr_idx, qos_map_pkg::IDX_CP_MAP0)) begin
                state_next.cp_map0[31:0] = hwdata;
            end
            if (idx_is(state_reg.wr_idx, qos_map_pkg::IDX_CP_MAP0 + 8'h01)) begin
                state_next.cp_map0[47:32] = hwdata[15:0];
            end
            if (idx_is(state_reg.wr_idx, qos_map_pkg::IDX_CP_MAP1)) begin
                state_next.cp_map1[31:0] = hwdata;
            end
            if (idx_is(state_reg.wr_idx, qos_map_pkg::IDX_CP_MAP1 + 8'h01)) begin
                state_next.cp_map1[47:32] = hwdata[15:0];
            end
            if (idx_is(state_reg.wr_idx, qos_map_pkg::IDX_CP_MAP2)) begin
                state_next.cp_map2[31:0] = hwdata;
            end
            if (idx_is(state_reg.wr_idx, qos_map_pkg::IDX_CP_MAP2 + 8'h01)) begin
                state_next.cp_map2[47:32] = hwdata[15:0];
            end
        end

        // Reads take one wait state so that a write just ahead is visible.
        state_next.rd_wait   = 1'b0;
        state_next.hreadyout = 1'b1;
        if (state_reg.rd_wait) begin
            state_next.hrdata = read_word(state_reg, state_reg.rd_idx);
        end
        accept = hsel && htrans[1] && hready;
        if (accept) begin
            if (hwrite) begin
                state_next.wr_pend = 1'b1;
                state_next.wr_idx  = haddr[qos_map_pkg::ADDR_IDX_LSB +: 8];
            end else begin
                state_next.rd_wait   = 1'b1;
                state_next.rd_idx    = haddr[qos_map_pkg::ADDR_IDX_LSB +: 8];
                state_next.hreadyout = 1'b0;
            end
        end

        // First stage holds the request and presents its code point outward, whatever its bank.
        // Fields load only on a request, so the forwarded code stands until the next one.
        state_next.s1_valid = lookup_valid;
        if (lookup_valid) begin
            state_next.s1_port      = lookup_port;
            state_next.s1_tagged    = lookup_tagged;
            state_next.s1_is_ip     = lookup_is_ip;
            state_next.s1_tag       = lookup_tag;
            state_next.s1_cp        = lookup_codepoint;
            state_next.s1_mac_prio  = lookup_mac_prio;
            state_next.s1_port_prio = lookup_port_prio;
        end

        // Second stage: source selection. Ports above 16 have no enable bits.
        if (state_reg.s1_port <= 5'd16) begin
            tag_ok = state_reg.tag_en[state_reg.s1_port] && state_reg.s1_tagged;
            cp_ok  = state_reg.cp_en[state_reg.s1_port];
        end
        tag_term = tag_ok ? tag_prio : 3'h0;
        cp_term  = cp_ok ? cp_prio : 3'h0;
        l2_prio  = tag_ok ? tag_prio : state_reg.s1_mac_prio;
        unique case (qos_map_pkg::src_sel_e'(state_reg.src_sel))
            qos_map_pkg::SRC_L2:         result = l2_prio;
            qos_map_pkg::SRC_IP_ONLY:    result = cp_term;
            qos_map_pkg::SRC_IP_ELSE_L2: result = state_reg.s1_is_ip ? cp_term : l2_prio;
            qos_map_pkg::SRC_MAX: begin
                result = max3(tag_term, cp_term);
                if (state_reg.port_qos_en) begin
                    result = max3(result, state_reg.s1_port_prio);
                end
            end
        endcase
        if (state_reg.port_qos_en && (state_reg.src_sel != qos_map_pkg::SRC_MAX)) begin
            result = state_reg.s1_port_prio;
        end
        state_next.prio_valid = state_reg.s1_valid;
        state_next.prio_id    = state_reg.s1_valid ? result : state_reg.prio_id;
        if (state_reg.s1_valid) begin
            state_next.last_valid = 1'b1;
            state_next.last_prio  = result;
        end
    end

    // ========================================================================
    // Registers. Tables and enables reset to zero, so a lookup yields the MAC priority unless the strap sets the port override.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ========================================================================
    // Outputs.
    assign hreadyout   = state_reg.hreadyout;
    assign hrdata      = state_reg.hrdata;
    assign hresp       = state_reg.hresp;
    assign cp_ext_code = state_reg.s1_cp;
    assign prio_valid  = state_reg.prio_valid;
    assign prio_id     = state_reg.prio_id;

endmodule

/* verif/qos_companion_model.sv */
// Model of the companion table that answers code points 48 to 63.
`timescale 1ns/1ps
module qos_companion_model (
    input  wire logic [5:0] cp_ext_code,
    output logic      [2:0] cp_ext_prio
);
    // ====================
    // Lookup
    // The answer follows the code, so a stale or misrouted answer shows up.
    always_comb begin
        cp_ext_prio = cp_ext_code[2:0] ^ 3'h5;
    end
endmodule

/* verif/qos_map_chk_chk.sv */
// Checker of bus timing and lookup pipeline at the map table ports.
`timescale 1ns/1ps
module qos_map_chk (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       lookup_valid,
    input wire logic [5:0] lookup_codepoint,
    input wire logic [5:0] cp_ext_code,
    input wire logic       prio_valid,
    input wire logic [2:0] prio_id
);
    // ====================
    // Properties
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic take;
    assign take = hsel && htrans[1] && hready;
    sequence read_wait_s;
        !hreadyout ##1 hreadyout;
    endsequence
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    read_wait_a: assert property (take && !hwrite |=> read_wait_s)
        else $error("read wait state wrong");
    write_fast_a: assert property (take && hwrite |=> hreadyout)
        else $error("write was stalled");
    low_once_a: assert property (!hreadyout |=> hreadyout)
        else $error("ready low too long");
    code_fwd_a: assert property (lookup_valid |=>
        cp_ext_code == $past(lookup_codepoint))
        else $error("code point not forwarded");
    code_hold_a: assert property (!lookup_valid |=> $stable(cp_ext_code))
        else $error("forwarded code changed");
    result_lat_a: assert property (lookup_valid |-> ##2 prio_valid)
        else $error("result late or missing");
    result_cause_a: assert property (prio_valid |-> $past(lookup_valid, 2))
        else $error("result without request");
    id_hold_a: assert property (!prio_valid |-> $stable(prio_id))
        else $error("priority changed between results");
endmodule

bind qos_priority_map_tables qos_map_chk u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .lookup_valid(lookup_valid),
    .lookup_codepoint(lookup_codepoint), .cp_ext_code(cp_ext_code),
    .prio_valid(prio_valid), .prio_id(prio_id));

/* verif/tb_top.sv */
// Self-checking bench for the QoS priority map tables.
`timescale 1ns/1ps
module tb_top;
    // ====================
    // Signals
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout, hresp, prio_valid;
    logic [31:0] hrdata, rd, tw;
    logic        port_qos_strap = 1'b0;
    logic        lookup_valid = 1'b0, lookup_tagged = 1'b0, lookup_is_ip = 1'b0;
    logic [4:0]  lookup_port = 5'h0;
    logic [2:0]  lookup_tag = 3'h0, lookup_mac_prio = 3'h3, lookup_port_prio = 3'h7;
    logic [5:0]  lookup_codepoint = 6'h0, cp_ext_code;
    logic [2:0]  cp_ext_prio, prio_id;
    logic [47:0] w;
    logic [7:0]  cpi [3] = '{qos_map_pkg::IDX_CP_MAP0, qos_map_pkg::IDX_CP_MAP1,
                            qos_map_pkg::IDX_CP_MAP2};
    logic [7:0]  rsti [12] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h30, 8'h31, 8'h36, 8'h37,
                              8'h3c, 8'h3d, 8'h05, 8'h20};
    int          fails = 0, compares = 0;

    always #12.5 hclk = ~hclk;

    qos_priority_map_tables dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .port_qos_strap(port_qos_strap), .lookup_valid(lookup_valid),
        .lookup_port(lookup_port), .lookup_tagged(lookup_tagged),
        .lookup_is_ip(lookup_is_ip), .lookup_tag(lookup_tag),
        .lookup_codepoint(lookup_codepoint), .lookup_mac_prio(lookup_mac_prio),
        .lookup_port_prio(lookup_port_prio), .cp_ext_code(cp_ext_code),
        .cp_ext_prio(cp_ext_prio), .prio_valid(prio_valid), .prio_id(prio_id));

    qos_companion_model partner (.cp_ext_code(cp_ext_code), .cp_ext_prio(cp_ext_prio));

    // ====================
    // Tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One single AHB transfer; read data land in rd.
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'h0};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        check(what, rd, exp);
    endtask

    // The result is looked at once the second edge after the request has landed.
    task automatic look(input logic [4:0] p, input logic tg, input logic ip,
                        input logic [2:0] t, input logic [5:0] c, input logic [2:0] exp);
        @(posedge hclk);
        lookup_valid <= 1'b1;
        lookup_port <= p;
        lookup_tagged <= tg;
        lookup_is_ip <= ip;
        lookup_tag <= t;
        lookup_codepoint <= c;
        @(posedge hclk);
        lookup_valid <= 1'b0;
        @(posedge hclk);
        #1;
        check("result valid", {31'h0, prio_valid}, 32'h1);
        check("priority id", {29'h0, prio_id}, {29'h0, exp});
    endtask

    task automatic do_reset(input logic s);
        port_qos_strap <= s;
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
    endtask

    function automatic logic [2:0] cpx(input int d);
        return (d >= 48) ? (3'(d) ^ 3'h5) : 3'(d % 16 + d / 16);
    endfunction

    // ====================
    // Tests
    initial begin
        do_reset(1'b0);
        foreach (rsti[i]) rchk("reset value", rsti[i], 32'h0);
        $display("test reset values done");
        xfer(1'b1, 8'h05, 32'hffffffff);
        rchk("unmapped", 8'h05, 32'h0);
        xfer(1'b1, qos_map_pkg::IDX_TAG_MAP, 32'hffffffff);
        rchk("tag map", qos_map_pkg::IDX_TAG_MAP, 32'h00ffffff);
        tw = 32'h0;
        for (int t = 0; t < 8; t++) tw[3*t +: 3] = 3'(7 - t);
        xfer(1'b1, qos_map_pkg::IDX_TAG_MAP, tw);
        rchk("tag map", qos_map_pkg::IDX_TAG_MAP, tw);
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 16; i++) w[3*i +: 3] = 3'(i + k);
            xfer(1'b1, cpi[k] + 8'h1, 32'hffffffff);
            rchk("cp high", cpi[k] + 8'h1, 32'h0000ffff);
            xfer(1'b1, cpi[k], w[31:0]);
            xfer(1'b1, cpi[k] + 8'h1, {16'h0, w[47:32]});
            rchk("cp low", cpi[k], w[31:0]);
        end
        xfer(1'b1, qos_map_pkg::IDX_TAG_EN, 32'h00010000);
        xfer(1'b1, qos_map_pkg::IDX_CP_EN, 32'h00010001);
        rchk("cp enable", qos_map_pkg::IDX_CP_EN, 32'h00010001);
        $display("test register access done");
        for (int t = 0; t < 8; t++) look(5'd16, 1'b1, 1'b0, 3'(t), 6'h0, 3'(7 - t));
        look(5'd16, 1'b0, 1'b0, 3'h5, 6'h0, 3'h3);
        look(5'd15, 1'b1, 1'b0, 3'h5, 6'h0, 3'h3);
        $display("test tag lookup done");
        xfer(1'b1, qos_map_pkg::IDX_GLOBAL_CTRL, 32'h4);
        for (int d = 0; d < 64; d++) begin
            look(5'd0, 1'b1, 1'b0, 3'h0, 6'(d), cpx(d));
        end
        look(5'd1, 1'b1, 1'b1, 3'h0, 6'h0f, 3'h0);
        $display("test code point lookup done");
        xfer(1'b1, qos_map_pkg::IDX_GLOBAL_CTRL, 32'h8);
        look(5'd16, 1'b1, 1'b1, 3'h2, 6'h2f, 3'h1);
        look(5'd16, 1'b1, 1'b0, 3'h2, 6'h2f, 3'h5);
        xfer(1'b1, qos_map_pkg::IDX_GLOBAL_CTRL, 32'hc);
        look(5'd16, 1'b1, 1'b1, 3'h2, 6'h2f, 3'h5);
        look(5'd16, 1'b1, 1'b1, 3'h7, 6'h2f, 3'h1);
        $display("test selector done");
        do_reset(1'b1);
        rchk("global control", qos_map_pkg::IDX_GLOBAL_CTRL, 32'h40);
        look(5'd16, 1'b1, 1'b1, 3'h2, 6'h2f, 3'h7);
        xfer(1'b1, qos_map_pkg::IDX_GLOBAL_CTRL, 32'h4c);
        xfer(1'b1, qos_map_pkg::IDX_TAG_EN, 32'h00010000);
        xfer(1'b1, qos_map_pkg::IDX_TAG_MAP, 32'h180);
        lookup_port_prio <= 3'h2;
        look(5'd16, 1'b1, 1'b0, 3'h2, 6'h0, 3'h6);
        look(5'd16, 1'b1, 1'b0, 3'h0, 6'h0, 3'h2);
        rchk("status", qos_map_pkg::IDX_STATUS, 32'h0000000a);
        $display("test port override done");
        report_and_stop();
    end

    // The tests take well under a thousand cycles; this allows five times that.
    initial begin
        #(25 * 5000);
        fails++;
        report_and_stop();
    end
endmodule
